// >>> hw/pwm_cfg.svh
// offsets, field positions, reset values and timing counts for the pwm block
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define REG_PERIOD 8'h00
`define REG_TIMER 8'h01
`define REG_TCTRL 8'h02
`define REG_FLAG 8'h03
`define REG_CH_BASE 8'h10
`define REG_CH_STRIDE 4
`define OFS_CTRL 2'h0
`define OFS_DUTY_HI 2'h1
`define OFS_DUTY_LO 2'h2
`define OFS_PORT 2'h3
`define BIT_EN 7
`define BIT_OE 6
`define BIT_OUT 5
`define BIT_INV 4
`define BIT_RUN 2
`define PRESC_MSB 1
`define PRESC_LSB 0
`define BIT_DIR 1
`define BIT_LATCH 0
`define DUTY_LO_MSB 7
`define DUTY_LO_LSB 6
`define PERIOD_RST 8'hff
`define TIMER_RST 8'h00
`define PRE_DIV1 2'h0
`define PRE_DIV4 2'h1
`define PRE_DIV16 2'h2
`define PRE_DIV64 2'h3
`define PRE_LAST1 6'h00
`define PRE_LAST4 6'h03
`define PRE_LAST16 6'h0f
`define PRE_LAST64 6'h3f
`define INSTR_DIV 4
`endif

// >>> hw/pwm_pkg.sv
// types shared by the pwm block
package pwm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] duty_t;
  typedef logic [1:0] presc_t;
endpackage

// >>> hw/shared_timebase_pwm.sv
// multi-channel pwm sharing one timer, period register and prescaler
// Overview of operation
// [R1] every channel has a ten-bit duty resolution
// [R2] all channels share one period; each has its own duty value
// [R3] no postscaler exists; only prescaler and period shape timing
// [R4] all outputs go active when the timer count clears
// [R5] output goes inactive when ten-bit time base equals buffered duty
// [R6] duty at or above the period setting never clears the output
// [R7] duty registers are double buffered, reloaded on period match
// [R8] after count equals period: clear, activate, reload; zero duty stays low
// [R9] invert bit flips the channel output level
// [R10] period is (period+1) times 4 system clocks times prescale
// [R11] high register holds eight msbs, low bits 7:6 hold two lsbs
// [R12] timer extended by two low bits counting at prescaled system clock
// [R13] full ten-bit resolution only with period 255
// [R14] pulse width beyond the period leaves the pin unchanged
// [R15] clock enable low freezes all state and pin levels
// [R16] reset makes all pins inputs and registers their reset values
// [R17] clearing drive enable hands the pin back to the port latch
// [R18] pwm is muxed with the port latch; direction must be output
// [R19] software follows the documented setup order for a clean first period
// [R20] the timer advances at one quarter of the system clock
// [R21] prescale codes 00,01,10,11 divide by 1,4,16,64
// [R22] disabled channel holds inactive level and stops comparing
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module shared_timebase_pwm #(
  parameter int CHANNELS = 4
) (
  // clock, reset and sleep freeze
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire pwm_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pwm_pkg::byte_t reg_rdata,
  // pins, output enable low while driving
  output logic [CHANNELS-1:0] pin_out,
  output logic [CHANNELS-1:0] pin_oe_n,
  // period match pulse for other peripherals
  output logic period_match
);
  import pwm_pkg::*;

  byte_t period_r;
  byte_t timer_r;
  logic [1:0] sub_r;
  logic [5:0] pre_r;
  presc_t presc_r;
  logic run_r;
  logic flag_r;
  logic match_r;
  logic [5:0] pre_last;
  logic tick;
  logic timer_wr;
  logic tctrl_wr;
  logic at_period;
  duty_t time_base;

  always_comb begin
    unique case (presc_r) // [R21]
      `PRE_DIV1: pre_last = `PRE_LAST1;
      `PRE_DIV4: pre_last = `PRE_LAST4;
      `PRE_DIV16: pre_last = `PRE_LAST16;
      `PRE_DIV64: pre_last = `PRE_LAST64;
    endcase
  end

  // one sub-step per prescaled system clock; four sub-steps per timer count
  assign tick = run_r && (pre_r == pre_last); // [R12] [R3]
  assign at_period = (timer_r == period_r) &&
    (sub_r == 2'(`INSTR_DIV - 1)); // [R20] [R10]
  assign time_base = {timer_r, sub_r}; // [R12] [R13]
  assign timer_wr = reg_wr && (reg_addr == `REG_TIMER);
  assign tctrl_wr = reg_wr && (reg_addr == `REG_TCTRL);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period_r <= `PERIOD_RST; // [R16]
    end else if (clk_en && reg_wr && reg_addr == `REG_PERIOD) begin
      period_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      presc_r <= `PRE_DIV1;
    end else if (clk_en && tctrl_wr) begin
      presc_r <= reg_wdata[`PRESC_MSB:`PRESC_LSB]; // [R21]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_r <= 1'b0;
    end else if (clk_en && tctrl_wr) begin
      run_r <= reg_wdata[`BIT_RUN];
    end
  end

  // prescaler cleared on timer or control writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_r <= '0;
    end else if (clk_en) begin // [R15]
      if (timer_wr || tctrl_wr || tick || !run_r) begin
        pre_r <= '0;
      end else begin
        pre_r <= pre_r + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_r <= `TIMER_RST;
      sub_r <= '0;
    end else if (clk_en) begin // [R15]
      if (timer_wr) begin
        timer_r <= reg_wdata;
        sub_r <= '0;
      end else if (tick) begin
        if (at_period) begin
          timer_r <= `TIMER_RST; // [R8]
          sub_r <= '0;
        end else begin
          {timer_r, sub_r} <= time_base + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      match_r <= 1'b0;
    end else if (clk_en) begin
      match_r <= tick && at_period;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (clk_en) begin
      if (tick && at_period) begin
        flag_r <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_FLAG &&
                   !reg_wdata[`BIT_LATCH]) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign period_match = match_r;

  logic [CHANNELS-1:0] en_r;
  logic [CHANNELS-1:0] oe_r;
  logic [CHANNELS-1:0] inv_r;
  logic [CHANNELS-1:0] lvl_r;
  logic [CHANNELS-1:0] dir_out_r;
  logic [CHANNELS-1:0] latch_r;
  byte_t ctrl_rd [CHANNELS];
  byte_t dhi_rd [CHANNELS];
  byte_t dlo_rd [CHANNELS];
  byte_t port_rd [CHANNELS];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      localparam logic [7:0] BASE = 8'(`REG_CH_BASE + g * `REG_CH_STRIDE);
      byte_t dhi_r;
      logic [1:0] dlo_r;
      duty_t buf_r;
      logic wr_ctrl;
      logic wr_hi;
      logic wr_lo;
      logic wr_port;
      duty_t period_base;
      assign wr_ctrl = reg_wr && reg_addr == BASE + 8'(`OFS_CTRL);
      assign wr_hi = reg_wr && reg_addr == BASE + 8'(`OFS_DUTY_HI);
      assign wr_lo = reg_wr && reg_addr == BASE + 8'(`OFS_DUTY_LO);
      assign wr_port = reg_wr && reg_addr == BASE + 8'(`OFS_PORT);
      assign period_base = {period_r, 2'(`INSTR_DIV - 1)};

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          en_r[g] <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
          en_r[g] <= reg_wdata[`BIT_EN];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          oe_r[g] <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
          oe_r[g] <= reg_wdata[`BIT_OE];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          inv_r[g] <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
          inv_r[g] <= reg_wdata[`BIT_INV];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          dir_out_r[g] <= 1'b0; // [R16]
        end else if (clk_en && wr_port) begin
          dir_out_r[g] <= reg_wdata[`BIT_DIR];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          latch_r[g] <= 1'b0;
        end else if (clk_en && wr_port) begin
          latch_r[g] <= reg_wdata[`BIT_LATCH];
        end
      end

      // written at any time; the compare sees only the buffer
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          dhi_r <= '0;
        end else if (clk_en && wr_hi) begin
          dhi_r <= reg_wdata; // [R11]
        end
      end

      // halves load independently, so a torn update lasts one period only
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          dlo_r <= '0;
        end else if (clk_en && wr_lo) begin
          dlo_r <= reg_wdata[`DUTY_LO_MSB:`DUTY_LO_LSB]; // [R11]
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          buf_r <= '0;
        end else if (clk_en && tick && at_period) begin
          buf_r <= {dhi_r, dlo_r}; // [R7] [R8] [R1]
        end
      end

      // lvl_r is the active-high waveform before inversion
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          lvl_r[g] <= 1'b0;
        end else if (clk_en) begin // [R15]
          if (!en_r[g]) begin
            lvl_r[g] <= 1'b0; // [R22]
          end else if (tick && at_period) begin
            // new duty takes effect with the new period
            lvl_r[g] <= ({dhi_r, dlo_r} != 10'h000); // [R4] [R8] [R2]
          end else if (tick && buf_r <= period_base &&
                       time_base + 10'h001 == buf_r) begin
            lvl_r[g] <= 1'b0; // [R5] [R6] [R14]
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pin_oe_n[g] <= 1'b1; // [R16]
        end else if (clk_en) begin // [R15]
          pin_oe_n[g] <= !dir_out_r[g]; // [R18]
        end
      end

      // pin level lags the waveform by one clock so the pin is a flop
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pin_out[g] <= 1'b0;
        end else if (clk_en) begin // [R15]
          if (oe_r[g]) begin
            pin_out[g] <= lvl_r[g] ^ inv_r[g]; // [R9] [R18]
          end else begin
            pin_out[g] <= latch_r[g]; // [R17]
          end
        end
      end

      assign ctrl_rd[g] = {
        en_r[g],
        oe_r[g],
        lvl_r[g] ^ inv_r[g],
        inv_r[g],
        4'h0
      };
      assign dhi_rd[g] = dhi_r;
      assign dlo_rd[g] = {dlo_r, 6'h00};
      assign port_rd[g] = {6'h00, dir_out_r[g], latch_r[g]};
    end
  endgenerate

  byte_t rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    unique case (reg_addr)
      `REG_PERIOD: rd_nxt = period_r;
      `REG_TIMER: rd_nxt = timer_r;
      `REG_TCTRL: rd_nxt = {5'h00, run_r, presc_r};
      `REG_FLAG: rd_nxt = {7'h00, flag_r};
      default: begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (reg_addr == 8'(`REG_CH_BASE + i * `REG_CH_STRIDE) +
              8'(`OFS_CTRL)) begin
            rd_nxt = ctrl_rd[i];
          end
          if (reg_addr == 8'(`REG_CH_BASE + i * `REG_CH_STRIDE) +
              8'(`OFS_DUTY_HI)) begin
            rd_nxt = dhi_rd[i];
          end
          if (reg_addr == 8'(`REG_CH_BASE + i * `REG_CH_STRIDE) +
              8'(`OFS_DUTY_LO)) begin
            rd_nxt = dlo_rd[i];
          end
          if (reg_addr == 8'(`REG_CH_BASE + i * `REG_CH_STRIDE) +
              8'(`OFS_PORT)) begin
            rd_nxt = port_rd[i];
          end
        end
      end
    endcase
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_nxt;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // shared_timebase_pwm

// >>> tb/shared_timebase_pwm_asserts.sv
// port-level assertions for the shared timebase pwm
`timescale 1ns/1ps
module shared_timebase_pwm_asserts #(parameter int CHANNELS = 4) (
  // clock, reset, sleep
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire pwm_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pwm_pkg::byte_t reg_rdata,
  // pins
  input wire logic [CHANNELS-1:0] pin_out,
  input wire logic [CHANNELS-1:0] pin_oe_n,
  input wire logic period_match
);
  import pwm_pkg::*;
  byte_t ctl_r;
  wire logic port_wr = clk_en && reg_wr && reg_addr == 8'h13;
  // mirror of the whole channel 0 control byte as written at 8'h10
  always_ff @(posedge ref_clk) begin
    if (reset) ctl_r <= 8'h00;
    else if (clk_en && reg_wr && reg_addr == 8'h10) ctl_r <= reg_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  reset_state_a: assert property (disable iff (1'b0)
    reset |=> &pin_oe_n && pin_out == '0 && !period_match)
    else $error("outputs off reset state");
  match_pulse_a: assert property (
    period_match && clk_en |=> !period_match) else $error("long match");
  match_gap_a: assert property (
    period_match && clk_en |=> ##1 !period_match [*2]) else $error("short");
  sleep_hold_a: assert property (
    !clk_en |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(reg_rdata))
    else $error("state moved in sleep");
  dir_set_a: assert property (
    port_wr && reg_wdata[1] |-> ##[1:2] !pin_oe_n[0]) else $error("no drive");
  dir_clear_a: assert property (
    port_wr && !reg_wdata[1] |-> ##[1:2] pin_oe_n[0]) else $error("driven");
  latch_high_a: assert property (
    port_wr && reg_wdata[0] && !ctl_r[6] |-> ##[1:2] pin_out[0])
    else $error("latch high lost");
  latch_low_a: assert property (
    port_wr && !reg_wdata[0] && !ctl_r[6] |-> ##[1:2] !pin_out[0])
    else $error("latch low lost");
  idle_level_a: assert property (
    clk_en && $past(clk_en) && !ctl_r[7] && ctl_r[6] && $stable(ctl_r) &&
    ctl_r == $past(ctl_r, 2) |-> pin_out[0] == ctl_r[4])
    else $error("disabled channel not idle");
endmodule // shared_timebase_pwm_asserts
bind shared_timebase_pwm shared_timebase_pwm_asserts #(.CHANNELS(CHANNELS))
  chk (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .period_match(period_match));

// >>> tb/shared_timebase_pwm_tb.sv
// self-checking bench for the shared timebase pwm
`timescale 1ns/1ps
module shared_timebase_pwm_tb;
  import pwm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  byte_t reg_rdata;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic period_match;
  int err_count = 0;
  int check_count = 0;
  integer seed = 32'hbc61_8b4d;
  int p, code, pre, d0, d1, len, h0, h1;
  bit inv;
  shared_timebase_pwm #(.CHANNELS(2)) dut (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .period_match(period_match));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp_reg(input byte_t got, input byte_t exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_wave(input int got, input int exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // a gap cycle after each strobe keeps back-to-back calls race free
  task automatic wr(input logic [7:0] a, input byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input byte_t exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp_reg(reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  // one period between match pulses; sleep cycles are not counted
  task automatic measure(input bit slp);
    int n;
    n = 0;
    while (period_match !== 1'b1 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    len = 0;
    h0 = 0;
    h1 = 0;
    do begin
      @(negedge ref_clk);
      len++;
      h0 += int'(pin_out[0] === 1'b1);
      h1 += int'(pin_out[1] === 1'b1);
      if (slp && len == 3) begin
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (30) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    end while (period_match !== 1'b1 && len < 9000);
    @(posedge ref_clk);
  endtask
  function automatic int exp_hi(int p, int pre, int d, bit inv);
    int per, h;
    per = (p + 1) * 4 * pre;
    h = (d >= 4 * (p + 1)) ? per : d * pre;
    return inv ? per - h : h;
  endfunction
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00, 8'hff);
    rd(8'h01, 8'h00);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    wr(8'h13, 8'h03);
    wr(8'h13, 8'h02);
    wr(8'h17, 8'h02);
    wr(8'h10, 8'h50);
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      code = i % 4;
      pre = 1 << (2 * code);
      p = {$random(seed)} % 8;
      inv = i[2];
      d0 = (i == 0) ? 0 : {$random(seed)} % (4 * p + 6);
      d1 = {$random(seed)} % (4 * p + 6);
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h00, 8'(p));
      wr(8'h11, 8'(d0 >> 2));
      wr(8'h12, 8'(d0 << 6));
      wr(8'h15, 8'(d1 >> 2));
      wr(8'h16, 8'(d1 << 6));
      wr(8'h10, {3'b110, inv, 4'h0});
      wr(8'h14, 8'hc0);
      wr(8'h02, 8'(4 + code));
      measure(1'b0);
      cmp_wave(len, (p + 1) * 4 * pre);
      cmp_wave(h0, exp_hi(p, pre, d0, inv));
      cmp_wave(h1, exp_hi(p, pre, d1, 1'b0));
      rd(8'h03, 8'h01);
      rd(8'h02, 8'(4 + code));
      rd(8'h11, 8'(d0 >> 2));
      rd(8'h16, 8'(d1 << 6));
    end
    measure(1'b1);
    cmp_wave(len, (p + 1) * 4 * pre);
    cmp_wave(h0, exp_hi(p, pre, d0, inv));
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00, 8'hff);
    rd(8'h10, 8'h00);
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule // shared_timebase_pwm_tb
